// >>> verilog/ubd_core.sv
// UART core: data/divisor and interrupt-enable registers, FIFOs, baud divider,
// serial and infrared transmitter and receiver, interrupt status.
// Assumes a plain register port on core_clk_i and asynchronous serial pins.
//
// How it works
// [R01] Data read returns received byte from active input
// [R02] Without FIFOs a new byte overwrites, flags overrun
// [R03] With FIFOs data read returns receive FIFO head
// [R04] Full receive FIFO drops new byte, flags overrun
// [R05] Software writes transmit data only when holding empty
// [R06] Without FIFOs a write clears holding-empty, later overwrite
// [R07] With FIFOs writes beyond depth are discarded
// [R08] Divisor access bit maps data address to divisor low
// [R09] Baud tick rate is clock over divisor, sixteen ticks per bit
// [R10] Zero divisor stops baud clock and all traffic
// [R11] Enable bit 7 selects programmable holding-empty mode
// [R12] Enable bit 3 gates modem status, fourth priority
// [R13] Enable bit 2 gates line status, highest priority
// [R14] Enable bit 1 gates holding-empty, third priority
// [R15] Enable bit 0 gates data available and timeout
// [R16] Divisor access maps enable bits to divisor high
// [R17] Infrared mode uses infrared input and inverted output
// [R18] Reserved enable bits read zero, ignore writes
`timescale 1ns/1ns
module ubd_core
  import ubd_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire ubd_bus_req_t bus_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic sin_i,
  input wire logic ir_rx_i,
  input wire logic cts_n_i,
  output logic tx_o,
  output logic ir_tx_n_o,
  output logic irq_o
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] HALF_CNT = (AW+1)'(DEPTH / 2);
  localparam logic [AW:0] ONE_CNT = (AW+1)'(1);

  typedef struct packed {
    logic [7:0] dll;
    logic [7:0] divisor_high_byte;
    logic [7:0] irq_enable_reg;
    logic fifo_en;
    logic divisor_access_bit;
    logic ir_mode;
    logic [15:0] baud_cnt;
    logic tick;
    logic [DEPTH-1:0][7:0] rx_mem;
    logic [AW-1:0] rx_rp;
    logic [AW-1:0] rx_wp;
    logic [AW:0] rx_cnt;
    logic [DEPTH-1:0][7:0] tx_mem;
    logic [AW-1:0] tx_rp;
    logic [AW-1:0] tx_wp;
    logic [AW:0] tx_cnt;
    logic overrun;
    ubd_rx_state_t rx_state;
    logic [3:0] rx_sub;
    logic [3:0] rx_bitn;
    logic [7:0] rx_shift;
    ubd_tx_state_t tx_state;
    logic [3:0] tx_sub;
    logic [3:0] tx_bitn;
    logic [9:0] tx_shift;
    logic sin_m;
    logic sin_s;
    logic ir_m;
    logic ir_s;
    logic cts_m;
    logic cts_s;
    logic cts_prev;
    logic tx_holding_empty_flag_prev;
    logic [9:0] to_cnt;
    logic to_fired;
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_mask;
    logic [DATA_W-1:0] rdata;
    logic irq;
    logic tx_line;
    logic ir_n;
  } ubd_state_t;

  // Idle line levels are high, so the serial and clear-to-send samples and outputs reset to one.
  function automatic ubd_state_t reset_state();
    ubd_state_t r;
    r = '0;
    r.dll = RST_DLL;
    r.divisor_high_byte = RST_DLH;
    r.irq_enable_reg = RST_IER;
    r.irq_mask = RST_IRQ_MASK;
    r.rx_state = RX_IDLE;
    r.tx_state = TX_IDLE;
    r.sin_m = 1'b1;
    r.sin_s = 1'b1;
    r.cts_m = 1'b1;
    r.cts_s = 1'b1;
    r.cts_prev = 1'b1;
    r.tx_holding_empty_flag_prev = 1'b1;
    r.tx_line = 1'b1;
    r.ir_n = 1'b1;
    return r;
  endfunction

  // Each event is gated by its enable bit; the timeout shares bit 0.
  function automatic logic [EV_W-1:0] ier_gate(input logic [7:0] irq_enable_reg);
    logic [EV_W-1:0] g;
    g = '0;
    g[EV_RX_AVAIL] = irq_enable_reg[IER_RX_AVAIL]; // R15
    g[EV_TIMEOUT] = irq_enable_reg[IER_RX_AVAIL]; // R15
    g[EV_TX_EMPTY] = irq_enable_reg[IER_TX_EMPTY]; // R14
    g[EV_LINE] = irq_enable_reg[IER_LINE]; // R13
    g[EV_MODEM] = irq_enable_reg[IER_MODEM]; // R12
    return g;
  endfunction

  // Highest pending source: line status, data/timeout, holding empty, modem.
  function automatic ubd_irq_id_t irq_prio(input logic [EV_W-1:0] act);
    if (act[EV_LINE]) return IRQ_LINE; // R13
    if (act[EV_RX_AVAIL] || act[EV_TIMEOUT]) return IRQ_RX; // R15
    if (act[EV_TX_EMPTY]) return IRQ_TX; // R14
    if (act[EV_MODEM]) return IRQ_MODEM; // R12
    return IRQ_NONE;
  endfunction

  ubd_state_t st;
  ubd_state_t next_st;

  logic [15:0] divisor;
  logic rx_line;
  logic thr_wr;
  logic rbr_rd;
  logic rx_pop;
  logic rx_done;
  logic rx_stored;
  logic rx_ovr;
  logic tx_pop;
  logic tx_holding_empty_flag_lvl;
  logic tx_bit;
  logic to_ev;
  logic [7:0] rx_head;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] active;

  always_comb begin
    next_st = st;
    divisor = {st.divisor_high_byte, st.dll};
    rx_head = st.rx_mem[st.rx_rp];
    tx_pop = 1'b0;
    rx_done = 1'b0;
    rx_stored = 1'b0;
    rx_ovr = 1'b0;
    to_ev = 1'b0;
    ev = '0;

    // Baud divider: one tick per divisor cycles, none while divisor is zero.
    next_st.tick = 1'b0;
    if (divisor == 16'h0000) begin
      next_st.baud_cnt = 16'h0000; // R10
    end else if (st.baud_cnt >= divisor - 16'h0001) begin
      next_st.baud_cnt = 16'h0000;
      next_st.tick = 1'b1; // R09
    end else begin
      next_st.baud_cnt = st.baud_cnt + 16'h0001;
    end

    next_st.sin_m = sin_i;
    next_st.sin_s = st.sin_m;
    next_st.ir_m = ir_rx_i;
    next_st.ir_s = st.ir_m;
    next_st.cts_m = cts_n_i;
    next_st.cts_s = st.cts_m;
    // An infrared pulse marks a zero bit.
    rx_line = st.ir_mode ? ~st.ir_s : st.sin_s; // R17

    thr_wr = bus_i.wr && bus_i.addr == ADDR_DATA && !st.divisor_access_bit;
    rbr_rd = bus_i.rd && bus_i.addr == ADDR_DATA && !st.divisor_access_bit;
    rx_pop = rbr_rd && st.rx_cnt != '0;

    // Receiver: start bit found, then each bit sampled at mid-bit.
    if (st.tick) begin
      case (st.rx_state)
        RX_IDLE: begin
          if (!rx_line) begin
            next_st.rx_state = RX_RECV;
            next_st.rx_sub = 4'h0;
            next_st.rx_bitn = 4'h0;
          end
        end
        RX_RECV: begin
          next_st.rx_sub = st.rx_sub + 4'h1;
          if (st.rx_sub == SAMPLE_TICK) begin
            if (st.rx_bitn == 4'h0 && rx_line) begin
              next_st.rx_state = RX_IDLE;
            end else if (st.rx_bitn == STOP_BIT) begin
              next_st.rx_state = RX_IDLE;
              rx_done = rx_line; // R01
            end else if (st.rx_bitn != 4'h0) begin
              next_st.rx_shift = {rx_line, st.rx_shift[7:1]};
            end
          end
          if (st.rx_sub == LAST_TICK) begin
            next_st.rx_bitn = st.rx_bitn + 4'h1;
          end
        end
        default: next_st.rx_state = RX_IDLE;
      endcase
    end

    // Receive buffer and FIFO.
    if (st.fifo_en) begin
      rx_stored = rx_done && st.rx_cnt != FULL_CNT;
      rx_ovr = rx_done && st.rx_cnt == FULL_CNT; // R04
      if (rx_stored) begin
        next_st.rx_mem[st.rx_wp] = st.rx_shift;
        next_st.rx_wp = st.rx_wp + 1'b1;
      end
      if (rx_pop) begin
        next_st.rx_rp = st.rx_rp + 1'b1; // R03
      end
      next_st.rx_cnt = st.rx_cnt + {{AW{1'b0}}, rx_stored} - {{AW{1'b0}}, rx_pop};
    end else begin
      rx_stored = rx_done;
      rx_ovr = rx_done && st.rx_cnt != '0 && !rx_pop; // R02
      if (rx_done) begin
        next_st.rx_mem[0] = st.rx_shift; // R02
        next_st.rx_cnt = ONE_CNT;
      end else if (rx_pop) begin
        next_st.rx_cnt = '0;
      end
    end

    // Transmitter: start bit, eight data bits, stop bit.
    case (st.tx_state)
      TX_IDLE: begin
        if (st.tick && st.tx_cnt != '0) begin
          next_st.tx_shift = {1'b1, st.tx_mem[st.tx_rp], 1'b0}; // R05
          next_st.tx_state = TX_SEND;
          next_st.tx_sub = 4'h0;
          next_st.tx_bitn = 4'h0;
          tx_pop = 1'b1;
        end
      end
      TX_SEND: begin
        if (st.tick) begin
          next_st.tx_sub = st.tx_sub + 4'h1;
          if (st.tx_sub == LAST_TICK) begin
            if (st.tx_bitn == STOP_BIT) begin
              next_st.tx_state = TX_IDLE;
            end else begin
              next_st.tx_bitn = st.tx_bitn + 4'h1;
              next_st.tx_shift = {1'b1, st.tx_shift[9:1]};
            end
          end
        end
      end
      default: next_st.tx_state = TX_IDLE;
    endcase
    tx_bit = (st.tx_state == TX_SEND) ? st.tx_shift[0] : 1'b1;
    next_st.tx_line = st.ir_mode ? 1'b1 : tx_bit; // R17
    next_st.ir_n = !(st.ir_mode && !tx_bit && st.tx_sub < IR_PULSE_TICKS); // R17

    // Transmit holding register and FIFO.
    if (st.fifo_en) begin
      if (thr_wr && st.tx_cnt != FULL_CNT) begin
        next_st.tx_mem[st.tx_wp] = bus_i.wdata[7:0]; // R07
        next_st.tx_wp = st.tx_wp + 1'b1;
        next_st.tx_cnt = st.tx_cnt + ONE_CNT - {{AW{1'b0}}, tx_pop};
      end else begin
        next_st.tx_cnt = st.tx_cnt - {{AW{1'b0}}, tx_pop}; // R07
      end
      if (tx_pop) begin
        next_st.tx_rp = st.tx_rp + 1'b1;
      end
    end else begin
      if (thr_wr) begin
        next_st.tx_mem[0] = bus_i.wdata[7:0]; // R06
        next_st.tx_cnt = ONE_CNT; // R06
      end else if (tx_pop) begin
        next_st.tx_cnt = '0;
      end
    end

    // Holding-empty event: empty, or at most half full in programmable mode with FIFOs on.
    if (st.irq_enable_reg[IER_PROG_TX_EMPTY_IRQ_MODE] && st.fifo_en) begin
      tx_holding_empty_flag_lvl = st.tx_cnt <= HALF_CNT; // R11
    end else begin
      tx_holding_empty_flag_lvl = st.tx_cnt == '0;
    end
    next_st.tx_holding_empty_flag_prev = tx_holding_empty_flag_lvl;

    // Character timeout: FIFO holds data, no traffic for four characters.
    if (!st.fifo_en || st.rx_cnt == '0 || rx_done || rx_pop || st.rx_state == RX_RECV) begin
      next_st.to_cnt = 10'h000;
      next_st.to_fired = 1'b0;
    end else if (st.tick && !st.to_fired) begin
      if (st.to_cnt == TIMEOUT_TICKS - 10'h001) begin
        to_ev = 1'b1; // R15
        next_st.to_fired = 1'b1;
        next_st.to_cnt = 10'h000;
      end else begin
        next_st.to_cnt = st.to_cnt + 10'h001;
      end
    end

    next_st.cts_prev = st.cts_s;
    ev[EV_RX_AVAIL] = rx_stored;
    ev[EV_TX_EMPTY] = tx_holding_empty_flag_lvl && !st.tx_holding_empty_flag_prev;
    ev[EV_LINE] = rx_ovr;
    ev[EV_MODEM] = st.cts_s != st.cts_prev;
    ev[EV_TIMEOUT] = to_ev;

    // Sticky flags: a new event wins over the clearing read.
    next_st.overrun = rx_ovr ||
      (st.overrun && !(bus_i.rd && bus_i.addr == ADDR_LINE_STATUS)); // R02 R04
    next_st.irq_stat = ev |
      ((bus_i.rd && bus_i.addr == ADDR_IRQ_STATUS) ? '0 : st.irq_stat);

    // Register writes.
    if (bus_i.wr) begin
      case (bus_i.addr)
        ADDR_DATA: begin
          if (st.divisor_access_bit) begin
            next_st.dll = bus_i.wdata[7:0]; // R08
          end
        end
        ADDR_IER_DLH: begin
          if (st.divisor_access_bit) begin
            next_st.divisor_high_byte = bus_i.wdata[7:0] & IER_MASK; // R16
          end else begin
            next_st.irq_enable_reg = bus_i.wdata[7:0] & IER_MASK; // R18
          end
        end
        ADDR_CTRL: begin
          next_st.fifo_en = bus_i.wdata[CTRL_FIFO_EN];
          next_st.divisor_access_bit = bus_i.wdata[CTRL_DIVISOR_ACCESS_BIT];
          next_st.ir_mode = bus_i.wdata[CTRL_IR_MODE];
          // Changing FIFO mode empties both buffers.
          if (bus_i.wdata[CTRL_FIFO_EN] != st.fifo_en) begin
            next_st.rx_rp = '0;
            next_st.rx_wp = '0;
            next_st.rx_cnt = '0;
            next_st.tx_rp = '0;
            next_st.tx_wp = '0;
            next_st.tx_cnt = '0;
          end
        end
        ADDR_IRQ_MASK: next_st.irq_mask = bus_i.wdata[EV_W-1:0];
        default: ;
      endcase
    end

    active = next_st.irq_stat & next_st.irq_mask & ier_gate(next_st.irq_enable_reg);
    next_st.irq = |active;

    // Register reads: data stands for one cycle only.
    next_st.rdata = '0;
    if (bus_i.rd) begin
      case (bus_i.addr)
        ADDR_DATA: next_st.rdata[7:0] = st.divisor_access_bit ? st.dll : rx_head; // R01 R03 R08
        ADDR_IER_DLH: next_st.rdata[7:0] = st.divisor_access_bit ? st.divisor_high_byte : st.irq_enable_reg; // R16 R18
        ADDR_CTRL: begin
          next_st.rdata[CTRL_FIFO_EN] = st.fifo_en;
          next_st.rdata[CTRL_DIVISOR_ACCESS_BIT] = st.divisor_access_bit;
          next_st.rdata[CTRL_IR_MODE] = st.ir_mode;
        end
        ADDR_LINE_STATUS: begin
          next_st.rdata[LS_DATA_READY] = st.rx_cnt != '0;
          next_st.rdata[LS_OVERRUN] = st.overrun;
          next_st.rdata[LS_TX_HOLDING_EMPTY_FLAG] = st.tx_cnt == '0;
          next_st.rdata[LS_TX_IDLE] = st.tx_cnt == '0 && st.tx_state == TX_IDLE;
          next_st.rdata[LS_IRQ_ID +: 3] = irq_prio(st.irq_stat & ier_gate(st.irq_enable_reg));
        end
        ADDR_IRQ_STATUS: next_st.rdata[EV_W-1:0] = st.irq_stat;
        ADDR_IRQ_MASK: next_st.rdata[EV_W-1:0] = st.irq_mask;
        default: next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st <= reset_state();
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign tx_o = st.tx_line;
  assign ir_tx_n_o = st.ir_n;
  assign irq_o = st.irq;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // The period is judged only while the divisor holds still for a whole period.
  sequence div3_held;
    (divisor == 16'h0003) [*3];
  endsequence

  chk_rbr_fifo_head: assert property ( // R03
    (rbr_rd && st.fifo_en && st.rx_cnt != '0) |=> rdata_o[7:0] == $past(rx_head))
    else $error("receive read did not return the FIFO head");
  chk_rx_full_drop: assert property ( // R04
    (st.fifo_en && rx_done && st.rx_cnt == FULL_CNT && !rx_pop && !bus_i.wr)
    |=> (st.rx_cnt == FULL_CNT && st.overrun && st.rx_mem == $past(st.rx_mem)))
    else $error("full receive FIFO did not keep data or flag overrun");
  chk_rx_overwrite: assert property ( // R02
    (!st.fifo_en && rx_done && st.rx_cnt != '0 && !rx_pop && !bus_i.wr)
    |=> (st.overrun && st.rx_mem[0] == $past(st.rx_shift)))
    else $error("unread byte not overwritten with overrun");
  chk_thr_write: assert property ( // R06
    (!st.fifo_en && thr_wr && !bus_i.rd) |=> (st.tx_cnt == ONE_CNT &&
      st.tx_mem[0] == $past(bus_i.wdata[7:0])))
    else $error("holding write did not clear holding-empty");
  chk_tx_full_drop: assert property ( // R07
    (st.fifo_en && thr_wr && st.tx_cnt == FULL_CNT && !tx_pop) |=> st.tx_cnt == FULL_CNT)
    else $error("write to full transmit FIFO was not discarded");
  chk_baud_period: assert property ( // R09
    (st.tick && divisor == 16'h0003) ##1 div3_held
    |-> (st.tick && !$past(st.tick) && !$past(st.tick, 2)))
    else $error("baud tick period differs from divisor");
  chk_zero_divisor: assert property ( // R10
    (divisor == 16'h0000) |=> !st.tick)
    else $error("baud tick while divisor is zero");
  chk_dll_write: assert property ( // R08
    (bus_i.wr && bus_i.addr == ADDR_DATA && st.divisor_access_bit)
    |=> (divisor[7:0] == $past(bus_i.wdata[7:0]) && st.tx_cnt <= $past(st.tx_cnt)))
    else $error("divisor low write not taken or reached transmit data");
  chk_ier_reserved: assert property ( // R18
    (bus_i.rd && bus_i.addr == ADDR_IER_DLH) |=> (rdata_o[15:8] == 8'h00 &&
      rdata_o[6:4] == 3'h0))
    else $error("reserved enable bits read nonzero");
  chk_ir_idle_out: assert property ( // R17
    !st.ir_mode |=> ir_tx_n_o)
    else $error("infrared output active outside infrared mode");

endmodule

// >>> verilog/ubd_pkg.sv
// Constants, register map and shared types of the buffered UART core.
// Assumes a single 20 MHz core clock that also serves as the serial clock.
package ubd_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 16;

  // Register byte addresses.
  localparam logic [31:0] ADDR_DATA = 32'h5000_1100;
  localparam logic [31:0] ADDR_IER_DLH = 32'h5000_1104;
  localparam logic [31:0] ADDR_CTRL = 32'h5000_1110;
  localparam logic [31:0] ADDR_LINE_STATUS = 32'h5000_1114;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h5000_1118;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h5000_111C;

  // Interrupt enable field positions and the mask of implemented bits.
  localparam int IER_RX_AVAIL = 0;
  localparam int IER_TX_EMPTY = 1;
  localparam int IER_LINE = 2;
  localparam int IER_MODEM = 3;
  localparam int IER_PROG_TX_EMPTY_IRQ_MODE = 7;
  localparam logic [7:0] IER_MASK = 8'h8F;

  // Control register field positions.
  localparam int CTRL_FIFO_EN = 0;
  localparam int CTRL_IR_MODE = 6;
  localparam int CTRL_DIVISOR_ACCESS_BIT = 7;

  // Line status field positions.
  localparam int LS_DATA_READY = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_TX_HOLDING_EMPTY_FLAG = 5;
  localparam int LS_TX_IDLE = 6;
  localparam int LS_IRQ_ID = 8;

  // Event bits of the interrupt status and mask registers.
  localparam int EV_RX_AVAIL = 0;
  localparam int EV_TX_EMPTY = 1;
  localparam int EV_LINE = 2;
  localparam int EV_MODEM = 3;
  localparam int EV_TIMEOUT = 4;
  localparam int EV_W = 5;

  // Reset values.
  localparam logic [7:0] RST_DLL = 8'h00;
  localparam logic [7:0] RST_DLH = 8'h00;
  localparam logic [7:0] RST_IER = 8'h00;
  localparam logic [4:0] RST_IRQ_MASK = 5'h00;

  // Timing counts in baud ticks (sixteen ticks per bit).
  localparam logic [3:0] SAMPLE_TICK = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'hF;
  localparam logic [3:0] STOP_BIT = 4'h9;
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
  localparam logic [9:0] TIMEOUT_TICKS = 10'h280;

  typedef enum logic [2:0] {
    IRQ_NONE = 3'h0,
    IRQ_LINE = 3'h1,
    IRQ_RX = 3'h2,
    IRQ_TX = 3'h3,
    IRQ_MODEM = 3'h4
  } ubd_irq_id_t;

  typedef enum logic {
    RX_IDLE = 1'b0,
    RX_RECV = 1'b1
  } ubd_rx_state_t;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } ubd_tx_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ubd_bus_req_t;

endpackage

// >>> testbench/ubd_peer.sv
// Remote serial peer: sends 8N1 frames to the core and decodes frames from it.
// Assumes bit_cycles core clocks per bit and ir_mode set by the bench.
`timescale 1ns/1ns
module ubd_peer (
  input wire logic core_clk_i,
  input wire logic tx_i,
  input wire logic ir_tx_n_i,
  output logic sin_o,
  output logic ir_rx_o
);
  int bit_cycles = 16;
  logic ir_mode = 1'b0;
  logic [7:0] rx_q[$];
  wire rx_line = ir_mode ? ir_tx_n_i : tx_i;

  initial begin
    sin_o = 1'b1;
    ir_rx_o = 1'b0;
  end

  // The infrared input carries the inverted level, so it idles low.
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk_i);
      if (ir_mode) begin
        ir_rx_o <= ~f[i];
      end else begin
        sin_o <= f[i];
      end
      repeat (bit_cycles - 1) @(posedge core_clk_i);
    end
  endtask

  // An infrared zero is a short low pulse at bit start, so it is sampled early.
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge rx_line);
      repeat (ir_mode ? 1 : bit_cycles / 2) @(posedge core_clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cycles) @(posedge core_clk_i);
        b[i] = rx_line;
      end
      repeat (bit_cycles) @(posedge core_clk_i);
      rx_q.push_back(b);
    end
  end
endmodule

// >>> testbench/ubd_core_tb.sv
// Self-checking bench of the UART core: registers, serial, infrared, interrupts.
// Assumes the serial peer model and a 20 MHz core clock.
`timescale 1ns/1ns
module ubd_core_tb;
  import ubd_pkg::*;
  localparam logic [31:0] A_DATA = ADDR_DATA;
  localparam logic [31:0] A_IEN = ADDR_IER_DLH;
  localparam logic [31:0] A_CTL = ADDR_CTRL;
  localparam logic [31:0] A_LST = ADDR_LINE_STATUS;
  localparam logic [31:0] A_IST = ADDR_IRQ_STATUS;
  localparam logic [31:0] A_IMK = ADDR_IRQ_MASK;
  localparam logic [31:0] B8 = 32'h0000_00FF;
  localparam logic [31:0] ID = 32'h0000_0700;
  logic core_clk_i;
  logic rst_i;
  logic cts_n_i;
  ubd_bus_req_t bus_i;
  logic [DATA_W-1:0] rdata_o;
  logic sin_i;
  logic ir_rx_i;
  logic tx_o;
  logic ir_tx_n_o;
  logic irq_o;
  int num_errors = 0;
  int check_count = 0;

  initial core_clk_i = 1'b0;

  always #25 core_clk_i = ~core_clk_i;

  ubd_core #(.DEPTH(4)) i_dut (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .bus_i(bus_i),
    .rdata_o(rdata_o),
    .sin_i(sin_i),
    .ir_rx_i(ir_rx_i),
    .cts_n_i(cts_n_i),
    .tx_o(tx_o),
    .ir_tx_n_o(ir_tx_n_o),
    .irq_o(irq_o)
  );

  ubd_peer i_peer (
    .core_clk_i(core_clk_i),
    .tx_i(tx_o),
    .ir_tx_n_i(ir_tx_n_o),
    .sin_o(sin_i),
    .ir_rx_o(ir_rx_i)
  );

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    bus_i.wr <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string n);
    @(posedge core_clk_i);
    bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    bus_i.rd <= 1'b0;
    #1;
    chk(n, e, rdata_o & m);
  endtask

  task automatic set_div(input logic [7:0] lo);
    wr(A_CTL, 32'h80);
    wr(A_DATA, {24'h0, lo});
    wr(A_CTL, 32'h00);
  endtask

  task automatic tx_start();
    for (int i = 0; i < 400 && tx_o === 1'b1; i++) @(negedge core_clk_i);
  endtask

  task automatic expect_tx(input logic [7:0] b);
    for (int i = 0; i < 8000 && i_peer.rx_q.size() == 0; i++) @(posedge core_clk_i);
    chk("tx byte", {24'h0, b}, (i_peer.rx_q.size() > 0) ? {24'h0, i_peer.rx_q.pop_front()} : 'x);
  endtask

  task automatic chk_irq(input logic e);
    repeat (6) @(negedge core_clk_i);
    chk("irq_o", {31'h0, e}, {31'h0, irq_o});
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge core_clk_i);
    num_errors++;
    $display("MISMATCH watchdog expected done seen timeout");
    complete_run();
  end

  initial begin
    int n;
    rst_i = 1'b1;
    cts_n_i = 1'b1;
    bus_i = '0;
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(A_IEN, 32'hFFFF_FFFF, 32'h0, "enable reset");
    wr(A_IEN, 32'hFFFF_FFFF);
    rd(A_IEN, 32'hFFFF_FFFF, 32'h8F, "enable bits");
    rd(32'h5000_1120, 32'hFFFF_FFFF, 32'h0, "unmapped");
    wr(A_IEN, 32'h05);
    $display("test enable register done");
    wr(A_CTL, 32'h80);
    rd(A_DATA, B8, 32'h0, "divisor low reset");
    wr(A_DATA, 32'h03);
    wr(A_IEN, 32'hFF);
    rd(A_DATA, B8, 32'h03, "divisor low");
    rd(A_IEN, 32'hFFFF_FFFF, 32'h8F, "divisor high");
    wr(A_IEN, 32'h00);
    wr(A_CTL, 32'h00);
    rd(A_IEN, 32'hFFFF_FFFF, 32'h05, "enable kept");
    i_peer.bit_cycles = 48;
    rd(A_LST, 32'h20, 32'h20, "holding empty");
    wr(A_DATA, 32'h41);
    tx_start();
    n = 0;
    while (tx_o === 1'b0 && n < 200) begin
      n++;
      @(negedge core_clk_i);
    end
    chk("start bit cycles", 32'd48, n);
    expect_tx(8'h41);
    $display("test divisor done");
    set_div(8'h00);
    wr(A_DATA, 32'hC3);
    n = 0;
    repeat (300) begin
      @(negedge core_clk_i);
      if (tx_o !== 1'b1) n++;
    end
    chk("stopped line", 32'd0, n);
    i_peer.bit_cycles = 16;
    set_div(8'h01);
    expect_tx(8'hC3);
    $display("test zero divisor done");
    i_peer.send(8'h5A);
    rd(A_LST, 32'h3, 32'h1, "data ready");
    rd(A_DATA, B8, 32'h5A, "rx byte");
    rd(A_LST, 32'h1, 32'h0, "ready cleared");
    i_peer.send(8'h11);
    i_peer.send(8'h22);
    rd(A_LST, 32'h3, 32'h3, "overrun");
    rd(A_DATA, B8, 32'h22, "overwritten");
    wr(A_DATA, 32'h12);
    tx_start();
    wr(A_DATA, 32'h34);
    rd(A_LST, 32'h20, 32'h0, "holding full");
    wr(A_DATA, 32'h56);
    expect_tx(8'h12);
    expect_tx(8'h56);
    $display("test plain buffer done");
    wr(A_CTL, 32'h01);
    for (int i = 0; i < 5; i++) i_peer.send(8'(8'h30 + i));
    rd(A_LST, 32'h3, 32'h3, "fifo overrun");
    for (int i = 0; i < 4; i++) rd(A_DATA, B8, 32'h30 + i, "fifo head");
    rd(A_LST, 32'h1, 32'h0, "fifo empty");
    i_peer.send(8'h44);
    rd(A_IST, 32'h10, 32'h0, "no early timeout");
    repeat (700) @(posedge core_clk_i);
    rd(A_IST, 32'h10, 32'h10, "char timeout");
    rd(A_DATA, B8, 32'h44, "timeout data");
    wr(A_IMK, 32'h1F);
    wr(A_IEN, 32'h82);
    wr(A_DATA, 32'h12);
    tx_start();
    for (int i = 0; i < 5; i++) wr(A_DATA, 32'h60 + i);
    rd(A_IST, 32'h0, 32'h0, "clear status");
    expect_tx(8'h12);
    expect_tx(8'h60);
    repeat (40) @(posedge core_clk_i);
    rd(A_IST, 32'h2, 32'h2, "early empty event");
    for (int i = 1; i < 4; i++) expect_tx(8'(8'h60 + i));
    repeat (400) @(posedge core_clk_i);
    chk("dropped write", 32'd0, 32'(i_peer.rx_q.size()));
    $display("test fifo done");
    wr(A_CTL, 32'h40);
    i_peer.ir_mode = 1'b1;
    i_peer.send(8'hA5);
    rd(A_DATA, B8, 32'hA5, "infrared rx");
    wr(A_DATA, 32'h3C);
    expect_tx(8'h3C);
    chk("serial idle", 32'h1, {31'h0, tx_o});
    i_peer.ir_mode = 1'b0;
    wr(A_CTL, 32'h00);
    $display("test infrared done");
    wr(A_IEN, 32'h00);
    rd(A_IST, 32'h0, 32'h0, "clear status");
    i_peer.send(8'h77);
    chk_irq(1'b0);
    @(posedge core_clk_i);
    cts_n_i <= 1'b0;
    wr(A_IEN, 32'h01);
    chk_irq(1'b1);
    wr(A_IEN, 32'h09);
    rd(A_LST, ID, 32'h200, "rx before modem");
    rd(A_IST, 32'h9, 32'h9, "rx and modem");
    rd(A_DATA, B8, 32'h77, "rx byte");
    chk_irq(1'b0);
    @(posedge core_clk_i);
    cts_n_i <= 1'b1;
    chk_irq(1'b1);
    rd(A_LST, ID, 32'h400, "modem id");
    rd(A_IST, 32'h8, 32'h8, "modem status");
    wr(A_IEN, 32'h0D);
    i_peer.send(8'h01);
    i_peer.send(8'h02);
    rd(A_LST, ID, 32'h100, "line first");
    rd(A_IST, 32'h5, 32'h5, "line status");
    rd(A_DATA, B8, 32'h02, "overrun data");
    wr(A_IEN, 32'h02);
    wr(A_DATA, 32'h9A);
    expect_tx(8'h9A);
    chk_irq(1'b1);
    rd(A_LST, ID, 32'h300, "tx id");
    rd(A_IST, 32'h2, 32'h2, "tx status");
    wr(A_IMK, 32'h00);
    wr(A_IEN, 32'h08);
    @(posedge core_clk_i);
    cts_n_i <= 1'b0;
    chk_irq(1'b0);
    rd(A_IST, 32'h8, 32'h8, "masked event");
    $display("test interrupts done");
    complete_run();
  end
endmodule
